// ==== design/charger_config_registers.v ====
// Register access over AXI4-Lite was left to the implementer.
`include "charger_cfg_defs.vh"

module charger_config_registers #(
	parameter [29:0] MINUTE_CYCLES = 30'h23C34600
)(
	input wire mclk,
	input wire resetn,
	input wire awvalid,
	output wire awready,
	input wire [7:0] awaddr,
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	output wire bvalid,
	input wire bready,
	output wire [1:0] bresp,
	input wire arvalid,
	output wire arready,
	input wire [7:0] araddr,
	output wire rvalid,
	input wire rready,
	output wire [31:0] rdata,
	output wire [1:0] rresp,
	input wire supply_present,
	input wire thermal_loop_active,
	input wire dppm_loop_active,
	input wire battery_below_exit,
	input wire termination_current_reached,
	input wire [7:0] battery_temp_c,
	output reg charger_on_r,
	output reg thermistor_curve_sel_r,
	output reg [11:0] precharge_exit_mv_r,
	output reg [12:0] regulation_mv_r,
	output reg [9:0] charge_current_ma_r,
	output reg [12:0] power_path_threshold_mv_r,
	output reg [7:0] termination_factor_tenths_r,
	output reg [7:0] charge_temp_max_c_r,
	output reg charge_current_en_r,
	output reg timer_expired_flag_r,
	output reg precharge_timeout_r
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_PRE = 3'h1;
	localparam [2:0] ST_FAST = 3'h2;
	localparam [2:0] ST_DONE = 3'h3;
	localparam [2:0] ST_FAULT = 3'h4;

	reg [7:0] cfg1_r;
	reg [7:0] cfg2_r;
	reg [7:0] cfg3_r;
	reg restart_r;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	wire wr_en;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire wr_lane;
	wire [7:0] rd_addr;
	reg [7:0] rd_data;
	wire rd_err;
	wire wr_err;
	wire pre_expired;
	wire fast_expired;
	wire slow;
	wire temp_ok;
	wire [9:0] fast_limit;
	wire [9:0] pre_limit;

	// ====================================================================
	// Helpers

	// Address to register select: 1..3 control, 4 status, 0 unmapped
	function [2:0] reg_sel;
		input [7:0] addr;
		begin
			if ({2'b00, addr} == {`IDX_CFG1, 2'b00})
				reg_sel = 3'h1;
			else if ({2'b00, addr} == {`IDX_CFG2, 2'b00})
				reg_sel = 3'h2;
			else if ({2'b00, addr} == {`IDX_CFG3, 2'b00})
				reg_sel = 3'h3;
			else if ({2'b00, addr} == {`IDX_STATUS, 2'b00})
				reg_sel = 3'h4;
			else
				reg_sel = 3'h0;
		end
	endfunction

	// Fast-charge duration in minutes
	function [9:0] fast_minutes;
		input [1:0] code;
		begin
			case (code)
				2'h0: fast_minutes = `FAST_MIN_00;
				2'h1: fast_minutes = `FAST_MIN_01;
				2'h2: fast_minutes = `FAST_MIN_10;
				default: fast_minutes = `FAST_MIN_11;
			endcase
		end
	endfunction

	// Pre-charge duration in minutes
	function [9:0] pre_minutes;
		input code;
		begin
			pre_minutes = code ? `PRE_MIN_1 : `PRE_MIN_0;
		end
	endfunction

	// ====================================================================
	// Bus front end
	axi_lite_slave u_bus (
		.mclk(mclk),
		.resetn(resetn),
		.awvalid(awvalid),
		.awready(awready),
		.awaddr(awaddr),
		.wvalid(wvalid),
		.wready(wready),
		.wdata(wdata),
		.wstrb(wstrb),
		.bvalid_r(bvalid),
		.bready(bready),
		.bresp_r(bresp),
		.arvalid(arvalid),
		.arready(arready),
		.araddr(araddr),
		.rvalid_r(rvalid),
		.rready(rready),
		.rdata_r(rdata),
		.rresp_r(rresp),
		.wr_en(wr_en),
		.wr_addr_r(wr_addr),
		.wr_data_r(wr_data),
		.wr_lane_r(wr_lane),
		.wr_err(wr_err),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	assign wr_err = (reg_sel(wr_addr) == 3'h0);
	assign rd_err = (reg_sel(rd_addr) == 3'h0);

	// ====================================================================
	// Register file

	// Control registers, byte lane 0 only
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfg1_r <= `CFG1_RST;
			cfg2_r <= `CFG2_RST;
			cfg3_r <= `CFG3_RST;
			restart_r <= 1'b0;
		end
		else
		begin
			// restart on falling edge of written bit
			restart_r <= wr_en && wr_lane && (reg_sel(wr_addr) == 3'h1) &&
				cfg1_r[`C1_RESTART] && !wr_data[`C1_RESTART];
			if (wr_en && wr_lane && reg_sel(wr_addr) == 3'h1)
				cfg1_r <= wr_data;
			if (wr_en && wr_lane && reg_sel(wr_addr) == 3'h2)
				cfg2_r <= wr_data;
			if (wr_en && wr_lane && reg_sel(wr_addr) == 3'h3)
				cfg3_r <= wr_data;
		end
	end

	// Read mux
	always @*
	begin
		rd_data = 8'h00;
		case (reg_sel(rd_addr))
			3'h1: rd_data = cfg1_r;
			3'h2: rd_data = cfg2_r;
			3'h3: rd_data = cfg3_r;
			3'h4: rd_data = {state_r, !temp_ok, (state_r == ST_DONE),
				precharge_timeout_r, timer_expired_flag_r, charge_current_en_r};
			default: rd_data = 8'h00;
		endcase
	end

	// ====================================================================
	// Safety timers
	assign fast_limit = fast_minutes(cfg1_r[`C1_TMR_HI:`C1_TMR_LO]);
	assign pre_limit = pre_minutes(cfg3_r[`C3_PRE_T]);
	// half rate under thermal or DPPM regulation
	assign slow = cfg2_r[`C2_SLOW] && (thermal_loop_active || dppm_loop_active);

	// runs only with timers enabled; held while suspended
	safety_timer #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_pre_timer (
		.mclk(mclk),
		.resetn(resetn),
		.clear(state_r != ST_PRE),
		.run(cfg1_r[`C1_SAFETY_TIMERS_ON] && !cfg1_r[`C1_HOLD]),
		.half_rate(slow),
		.limit_min(pre_limit),
		.expired_r(pre_expired)
	);

	// fast timer limit from the duration code
	safety_timer #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_fast_timer (
		.mclk(mclk),
		.resetn(resetn),
		.clear(state_r != ST_FAST),
		.run(cfg1_r[`C1_SAFETY_TIMERS_ON] && !cfg1_r[`C1_HOLD]),
		.half_rate(slow),
		.limit_min(fast_limit),
		.expired_r(fast_expired)
	);

	// ====================================================================
	// Charge sequence

	assign temp_ok = (battery_temp_c <= charge_temp_max_c_r);

	// Next state
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (supply_present)
					state_nxt = battery_below_exit ? ST_PRE : ST_FAST;
			ST_PRE:
				if (pre_expired && cfg1_r[`C1_SAFETY_TIMERS_ON])
					state_nxt = ST_FAULT;
				else if (!battery_below_exit)
					state_nxt = ST_FAST;
			ST_FAST:
				if (fast_expired && cfg1_r[`C1_SAFETY_TIMERS_ON])
					state_nxt = ST_FAULT;
				else if (termination_current_reached && !cfg1_r[`C1_NOTERM])
					state_nxt = ST_DONE;
			default:
				state_nxt = state_r;
		endcase
		// disabled charger, held restart or lost supply go idle
		if (!cfg1_r[`C1_ON] || cfg1_r[`C1_RESTART] || restart_r || !supply_present)
			state_nxt = ST_IDLE;
	end

	// State and timeout flags
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			timer_expired_flag_r <= 1'b0;
			precharge_timeout_r <= 1'b0;
			charge_current_en_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			charge_current_en_r <= ((state_nxt == ST_PRE) || (state_nxt == ST_FAST)) && temp_ok;
			// flag set wins over restart clear
			if (state_r != ST_FAULT && state_nxt == ST_FAULT)
				timer_expired_flag_r <= 1'b1;
			else if (restart_r)
				timer_expired_flag_r <= 1'b0;
			if (state_r == ST_PRE && state_nxt == ST_FAULT)
				precharge_timeout_r <= 1'b1;
			else if (restart_r)
				precharge_timeout_r <= 1'b0;
		end
	end

	// ====================================================================
	// Decoded settings to the analog side
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			charger_on_r <= 1'b1;
			thermistor_curve_sel_r <= 1'b0;
			precharge_exit_mv_r <= `EXIT_MV_0;
			regulation_mv_r <= `VREG_MV_00;
			charge_current_ma_r <= `ICHG_MA_00;
			power_path_threshold_mv_r <= `DPPM_MV_00;
			termination_factor_tenths_r <= `TERM_T_00;
			charge_temp_max_c_r <= `TMAX_C_0;
		end
		else
		begin
			charger_on_r <= cfg1_r[`C1_ON];
			thermistor_curve_sel_r <= cfg1_r[`C1_NTC];
			precharge_exit_mv_r <= cfg2_r[`C2_EXIT] ? `EXIT_MV_1 : `EXIT_MV_0;
			case (cfg2_r[`C2_VREG_HI:`C2_VREG_LO])
				2'h0: regulation_mv_r <= `VREG_MV_00;
				2'h1: regulation_mv_r <= `VREG_MV_01;
				2'h2: regulation_mv_r <= `VREG_MV_10;
				default: regulation_mv_r <= `VREG_MV_11;
			endcase
			case (cfg3_r[`C3_ICHG_HI:`C3_ICHG_LO])
				2'h0: charge_current_ma_r <= `ICHG_MA_00;
				2'h1: charge_current_ma_r <= `ICHG_MA_01;
				2'h2: charge_current_ma_r <= `ICHG_MA_10;
				default: charge_current_ma_r <= `ICHG_MA_11;
			endcase
			case (cfg3_r[`C3_DPPM_HI:`C3_DPPM_LO])
				2'h0: power_path_threshold_mv_r <= `DPPM_MV_00;
				2'h1: power_path_threshold_mv_r <= `DPPM_MV_01;
				2'h2: power_path_threshold_mv_r <= `DPPM_MV_10;
				default: power_path_threshold_mv_r <= `DPPM_MV_11;
			endcase
			case (cfg3_r[`C3_TERM_HI:`C3_TERM_LO])
				2'h0: termination_factor_tenths_r <= `TERM_T_00;
				2'h1: termination_factor_tenths_r <= `TERM_T_01;
				2'h2: termination_factor_tenths_r <= `TERM_T_10;
				default: termination_factor_tenths_r <= `TERM_T_11;
			endcase
			charge_temp_max_c_r <= cfg3_r[`C3_CHARGE_TEMP_WINDOW] ? `TMAX_C_1 : `TMAX_C_0;
		end
	end
endmodule // charger_config_registers

// ==== design/charger_cfg_defs.vh ====
`ifndef CHARGER_CFG_DEFS_VH
`define CHARGER_CFG_DEFS_VH

// ====================================================================
// Register indices and address width
`define IDX_CFG1 8'h04
`define IDX_CFG2 8'h05
`define IDX_CFG3 8'h06
`define IDX_STATUS 8'h0F
`define ADDR_W 8

// ====================================================================
// Reset values
`define CFG1_RST 8'hB1
`define CFG2_RST 8'h80
`define CFG3_RST 8'hB2

// ====================================================================
// Field positions, first control register
`define C1_SAFETY_TIMERS_ON 7
`define C1_TMR_HI 6
`define C1_TMR_LO 5
`define C1_NTC 4
`define C1_RESTART 3
`define C1_NOTERM 2
`define C1_HOLD 1
`define C1_ON 0

// Field positions, second control register
`define C2_SLOW 7
`define C2_EXIT 6
`define C2_VREG_HI 5
`define C2_VREG_LO 4

// Field positions, third control register
`define C3_ICHG_HI 7
`define C3_ICHG_LO 6
`define C3_DPPM_HI 5
`define C3_DPPM_LO 4
`define C3_PRE_T 3
`define C3_TERM_HI 2
`define C3_TERM_LO 1
`define C3_CHARGE_TEMP_WINDOW 0

// ====================================================================
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ====================================================================
// Timing
`define CLK_HZ 32'h00989680
`define MINUTE_S 32'h0000003C
`define FAST_MIN_00 10'h0F0
`define FAST_MIN_01 10'h12C
`define FAST_MIN_10 10'h168
`define FAST_MIN_11 10'h1E0
`define PRE_MIN_0 10'h01E
`define PRE_MIN_1 10'h03C

// ====================================================================
// Analog settings in mV, mA, tenths of a percent, degrees C
`define EXIT_MV_0 12'hB54
`define EXIT_MV_1 12'h9C4
`define VREG_MV_00 13'h1004
`define VREG_MV_01 13'h1036
`define VREG_MV_10 13'h1068
`define VREG_MV_11 13'h109A
`define ICHG_MA_00 10'h12C
`define ICHG_MA_01 10'h190
`define ICHG_MA_10 10'h1F4
`define ICHG_MA_11 10'h2BC
`define DPPM_MV_00 13'h0DAC
`define DPPM_MV_01 13'h0EA6
`define DPPM_MV_10 13'h0FA0
`define DPPM_MV_11 13'h109A
`define TERM_T_00 8'h19
`define TERM_T_01 8'h4B
`define TERM_T_10 8'h96
`define TERM_T_11 8'hB4
`define TMAX_C_0 8'h2D
`define TMAX_C_1 8'h3C

`endif

// ==== design/safety_timer.v ====
`include "charger_cfg_defs.vh"

// ====================================================================
// Minute counter with prescaler, hold and half-rate
module safety_timer #(
	parameter [29:0] MINUTE_CYCLES = 30'h23C34600
)(
	input wire mclk,
	input wire resetn,
	input wire clear,
	input wire run,
	input wire half_rate,
	input wire [9:0] limit_min,
	output reg expired_r
);
	reg [29:0] pre_r;
	reg half_r;
	reg [9:0] min_r;
	wire wrap;

	assign wrap = (pre_r == MINUTE_CYCLES - 30'h1);

	// Prescaler and minute count
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pre_r <= 30'h0;
			half_r <= 1'b0;
			min_r <= 10'h0;
			expired_r <= 1'b0;
		end
		else if (clear)
		begin
			pre_r <= 30'h0;
			half_r <= 1'b0;
			min_r <= 10'h0;
			expired_r <= 1'b0;
		end
		else
		begin
			expired_r <= (min_r >= limit_min);
			if (run && !expired_r)
			begin
				pre_r <= wrap ? 30'h0 : pre_r + 30'h1;
				// every other minute tick when slowed
				if (wrap && half_rate && !half_r)
					half_r <= 1'b1;
				else if (wrap)
				begin
					half_r <= 1'b0;
					min_r <= min_r + 10'h1;
				end
			end
		end
	end
endmodule // safety_timer

// ==== design/axi_lite_slave.v ====
`include "charger_cfg_defs.vh"

// ====================================================================
// AXI4-Lite slave front end, one write and one read at a time
module axi_lite_slave (
	input wire mclk,
	input wire resetn,
	input wire awvalid,
	output wire awready,
	input wire [7:0] awaddr,
	input wire wvalid,
	output wire wready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	output reg bvalid_r,
	input wire bready,
	output reg [1:0] bresp_r,
	input wire arvalid,
	output wire arready,
	input wire [7:0] araddr,
	output reg rvalid_r,
	input wire rready,
	output reg [31:0] rdata_r,
	output reg [1:0] rresp_r,
	output wire wr_en,
	output reg [7:0] wr_addr_r,
	output reg [7:0] wr_data_r,
	output reg wr_lane_r,
	input wire wr_err,
	output wire [7:0] rd_addr,
	input wire [7:0] rd_data,
	input wire rd_err
);
	reg aw_full_r;
	reg w_full_r;

	// Handshakes
	assign awready = !aw_full_r && !bvalid_r;
	assign wready = !w_full_r && !bvalid_r;
	assign wr_en = aw_full_r && w_full_r;
	assign arready = !rvalid_r;
	assign rd_addr = araddr;

	// Write address, data and response
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
			wr_lane_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_full_r <= 1'b1;
				wr_addr_r <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_full_r <= 1'b1;
				wr_data_r <= wdata[7:0];
				wr_lane_r <= wstrb[0];
			end
			if (wr_en)
			begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	// Read data, one cycle after the address is taken
	always @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= `RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid_r <= 1'b1;
			rdata_r <= {24'h000000, rd_data};
			rresp_r <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
		end
		else if (rvalid_r && rready)
			rvalid_r <= 1'b0;
	end
endmodule // axi_lite_slave

// ==== dv/charger_config_registers_properties.sv ====
// ====================
// Bus and charge-enable checker
module charger_config_registers_properties (
	input wire mclk,
	input wire resetn,
	input wire awvalid,
	input wire awready,
	input wire wvalid,
	input wire wready,
	input wire bvalid,
	input wire bready,
	input wire [1:0] bresp,
	input wire arvalid,
	input wire arready,
	input wire [7:0] araddr,
	input wire rvalid,
	input wire rready,
	input wire [31:0] rdata,
	input wire [1:0] rresp,
	input wire [7:0] battery_temp_c,
	input wire charger_on_r,
	input wire [7:0] charge_temp_max_c_r,
	input wire charge_current_en_r
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, reset disables all
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	// ====================
	// Write channel
	a_write_answer:
		assert property (awvalid && awready && wvalid && wready |-> ##[1:3] bvalid)
		else $error("write response missing");
	a_write_holds:
		assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_aw_refused:
		assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	// ====================
	// Read channel
	a_read_answer:
		assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	a_read_holds:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read data dropped");
	a_ar_refused:
		assert property (rvalid |-> !arready)
		else $error("read taken during data");
	a_unmapped_read:
		assert property (arvalid && arready && !(araddr inside {8'h10, 8'h14, 8'h18, 8'h3C})
			|=> rresp == 2'h2 && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_upper_zero:
		assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	// ====================
	// Charge enable
	a_off_idle:
		assert property ((!charger_on_r) [*4] |-> !charge_current_en_r)
		else $error("charging while disabled");
	a_temp_window:
		assert property ((battery_temp_c > charge_temp_max_c_r) [*4] |-> !charge_current_en_r)
		else $error("charging outside window");
endmodule // charger_config_registers_properties

bind charger_config_registers charger_config_registers_properties u_props (.*);

// ==== dv/tb_charger_config_registers.sv ====
module tb_charger_config_registers;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, resetn, awvalid, wvalid, bready, arvalid, rready, supply_present;
	logic thermal_loop_active, dppm_loop_active, battery_below_exit;
	logic termination_current_reached;
	logic [7:0] awaddr, araddr, battery_temp_c, a, d;
	logic [31:0] wdata, rnd;
	logic [3:0] wstrb;
	logic [1:0] c;
	wire awready, wready, bvalid, arready, rvalid, charger_on_r, thermistor_curve_sel_r;
	wire charge_current_en_r, timer_expired_flag_r, precharge_timeout_r;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [11:0] precharge_exit_mv_r;
	wire [12:0] regulation_mv_r, power_path_threshold_mv_r;
	wire [9:0] charge_current_ma_r;
	wire [7:0] termination_factor_tenths_r, charge_temp_max_c_r;
	int bad_count = 0;
	int cmp_count = 0;
	int seed = 70;

	// Two clock cycles a minute
	charger_config_registers #(.MINUTE_CYCLES(30'h2)) dut (.*);

	// ====================
	// Clock and watchdog
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	initial
	begin
		repeat (32'h2710) @(posedge mclk);
		bad_count++;
		complete_run;
	end

	// ====================
	// Expected decodes
	function automatic logic [9:0] exp_ma(input logic [1:0] k);
		return (k == 2'h3) ? 10'h2BC : 10'h12C + 10'h064 * k;
	endfunction
	function automatic logic [12:0] exp_dp(input logic [1:0] k);
		return 13'h0DAC + 13'h00FA * k;
	endfunction
	function automatic logic [12:0] exp_vr(input logic [1:0] k);
		return 13'h1004 + 13'h0032 * k;
	endfunction
	function automatic logic [7:0] exp_tf(input logic [1:0] k);
		return (k == 2'h0) ? 8'h19 : (k == 2'h1) ? 8'h4B : (k == 2'h2) ? 8'h96 : 8'hB4;
	endfunction
	// Fast timer length in cycles
	function automatic int fast_cyc(input logic [1:0] k);
		return (k == 2'h3) ? 32'h3C0 : 32'h1E0 + 32'h78 * k;
	endfunction

	// ====================
	// Compare, bus cycles, ending
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] dv, input logic [1:0] er);
		@(posedge mclk);
		awaddr <= ad;
		wdata <= {24'h0, dv};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		bready <= 1'b0;
		chk(bresp, er);
	endtask
	task automatic rchk(input logic [7:0] ad, input logic [31:0] ed, input logic [1:0] er);
		@(posedge mclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		rready <= 1'b0;
		chk(rdata, ed);
		chk(rresp, er);
	endtask
	task automatic restart(input logic [7:0] v);
		wr(8'h10, v | 8'h08, 2'h0);
		wr(8'h10, v, 2'h0);
	endtask
	// Restart, then expect no expiry at lo and flag e at hi
	task automatic tmr(input logic [7:0] v, input int lo, input int hi, input logic e);
		restart(v);
		repeat (lo) @(posedge mclk);
		chk(timer_expired_flag_r, 32'h0);
		repeat (hi - lo) @(posedge mclk);
		chk(timer_expired_flag_r, {31'h0, e});
	endtask
	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ====================
	// Main sequence
	initial
	begin
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{thermal_loop_active, dppm_loop_active, termination_current_reached} = 3'h0;
		supply_present = 1'b1;
		battery_below_exit = 1'b1;
		battery_temp_c = 8'h19;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'h1;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		rchk(8'h10, 32'hB1, 2'h0);
		rchk(8'h14, 32'h80, 2'h0);
		rchk(8'h18, 32'hB2, 2'h0);
		chk(charger_on_r, 32'h1);
		chk(charge_current_ma_r, 32'h1F4);
		chk(power_path_threshold_mv_r, 32'h109A);
		chk(termination_factor_tenths_r, 32'h4B);
		chk(precharge_exit_mv_r, 32'hB54);
		// Every field code of the second and third control registers, and the thermistor bit
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			a = {c, c, c[0], c, c[0]};
			d = {c, c, 4'h0};
			wr(8'h18, a, 2'h0);
			wr(8'h14, d, 2'h0);
			wr(8'h10, {3'h5, c[0], 4'h1}, 2'h0);
			repeat (2) @(posedge mclk);
			chk(charge_current_ma_r, exp_ma(c));
			chk(power_path_threshold_mv_r, exp_dp(c));
			chk(termination_factor_tenths_r, exp_tf(c));
			chk(regulation_mv_r, exp_vr(c));
			chk(charge_temp_max_c_r, c[0] ? 32'h3C : 32'h2D);
			chk(precharge_exit_mv_r, c[0] ? 32'h9C4 : 32'hB54);
			chk(thermistor_curve_sel_r, c[0]);
			rchk(8'h18, {24'h0, a}, 2'h0);
		end
		// Random register traffic
		repeat (16)
		begin
			rnd = $random(seed);
			a = 8'h10 + {rnd[1:0] % 2'h3, 2'h0};
			d = rnd[15:8];
			if (a == 8'h14)
				d[3:0] = 4'h0;
			wr(a, d, 2'h0);
			rchk(a, {24'h0, d}, 2'h0);
		end
		wr(8'h20, 8'h5A, 2'h2);
		rchk(8'h20, 32'h0, 2'h2);
		// Pre-charge timer, disable, hold, slowdown
		wr(8'h14, 8'h00, 2'h0);
		wr(8'h18, 8'hB2, 2'h0);
		// Write with byte lane 0 off leaves the register alone
		wstrb <= 4'h0;
		wr(8'h18, 8'h00, 2'h0);
		wstrb <= 4'h1;
		rchk(8'h18, 32'hB2, 2'h0);
		tmr(8'h81, 32'h2D, 32'h5A, 1'b1);
		chk(precharge_timeout_r, 32'h1);
		chk(charge_current_en_r, 32'h0);
		rchk(8'h3C, 32'h86, 2'h0);
		tmr(8'h01, 32'h2D, 32'hC8, 1'b0);
		tmr(8'h83, 32'h2D, 32'hC8, 1'b0);
		wr(8'h10, 8'h81, 2'h0);
		repeat (32'h28) @(posedge mclk);
		chk(timer_expired_flag_r, 32'h0);
		repeat (32'h32) @(posedge mclk);
		chk(timer_expired_flag_r, 32'h1);
		wr(8'h14, 8'h80, 2'h0);
		thermal_loop_active <= 1'b1;
		tmr(8'h81, 32'h64, 32'hA0, 1'b1);
		thermal_loop_active <= 1'b0;
		dppm_loop_active <= 1'b1;
		tmr(8'h81, 32'h64, 32'hA0, 1'b1);
		dppm_loop_active <= 1'b0;
		// Fast timer codes
		battery_below_exit <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			c = i[1:0];
			tmr({1'b1, c, 5'h01}, fast_cyc(c) - 32'h28, fast_cyc(c) + 32'h28, 1'b1);
		end
		// Termination, temperature window, enable
		termination_current_reached <= 1'b1;
		restart(8'h81);
		repeat (32'h14) @(posedge mclk);
		chk(charge_current_en_r, 32'h0);
		restart(8'h85);
		repeat (32'h14) @(posedge mclk);
		chk(charge_current_en_r, 32'h1);
		battery_temp_c <= 8'h32;
		repeat (32'h6) @(posedge mclk);
		chk(charge_current_en_r, 32'h0);
		wr(8'h18, 8'hB3, 2'h0);
		repeat (32'h6) @(posedge mclk);
		chk(charge_current_en_r, 32'h1);
		wr(8'h10, 8'h84, 2'h0);
		repeat (32'h6) @(posedge mclk);
		chk(charge_current_en_r, 32'h0);
		chk(charger_on_r, 32'h0);
		complete_run;
	end
endmodule // tb_charger_config_registers
